// ==== hdl/maint_pkg.sv ====
package maint_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam longint CLK_HZ      = 64'd10_000_000;
  localparam longint HOUR_S      = 64'd3600;
  localparam longint HOUR_CYCLES = HOUR_S * CLK_HZ;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CUMULATIVE_HOURS      = 16'h004c;
  localparam logic [15:0] IDX_ENERGY_LOW_DIGITS     = 16'h005c;
  localparam logic [15:0] IDX_ENERGY_HIGH_DIGITS    = 16'h005d;
  localparam logic [15:0] IDX_HOTTEST_CELL_TEMP     = 16'h0068;
  localparam logic [15:0] IDX_RUN_COMMAND_COUNT     = 16'h0075;
  localparam logic [15:0] IDX_PEAK_CURRENT          = 16'h07cf;
  localparam logic [15:0] IDX_PEAK_CURRENT_FREQ     = 16'h07d0;
  localparam logic [15:0] IDX_OVERLOAD_ACCUMULATOR  = 16'h07d8;
  localparam logic [15:0] IDX_REFERENCE_SOURCE_CODE = 16'h07da;
  localparam logic [15:0] IDX_LINK_FREQ_REFERENCE   = 16'h07db;
  localparam logic [15:0] IDX_OPTION_FREQ_REFERENCE = 16'h07dc;
  localparam logic [15:0] IDX_HOUR_COUNT_CONDITION  = 16'h0800;
  localparam logic [15:0] IDX_HOUR_COUNTER_PRESET   = 16'h0801;
  localparam logic [15:0] IDX_RUN_COUNT_RESET       = 16'h0802;

  // ----------------------------------------------------------------
  // Wrap limits and reset values
  // ----------------------------------------------------------------
  localparam logic [16:0] HOURS_MAX       = 17'd99999;
  localparam logic [15:0] RUNS_MAX        = 16'd65535;
  localparam logic [13:0] ENERGY_LOW_MAX  = 14'd9999;
  localparam logic [16:0] ENERGY_HIGH_MAX = 17'd99999;
  localparam logic        RST_COUNT_ON_RUN = 1'b0;
  localparam logic [31:0] RST_ZERO32      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Reference source code digits (X*1000 + Y*100 + nn)
  // ----------------------------------------------------------------
  localparam logic [15:0] SRC_X_PRIMARY   = 16'd1;
  localparam logic [15:0] SRC_X_ALTERNATE = 16'd2;
  localparam logic [15:0] SRC_Y_PANEL     = 16'd0;
  localparam logic [15:0] SRC_Y_ANALOG    = 16'd1;
  localparam logic [15:0] SRC_Y_MULTISTEP = 16'd2;
  localparam logic [15:0] SRC_Y_LINK      = 16'd3;
  localparam logic [15:0] SRC_Y_OPTION    = 16'd4;
  localparam logic [15:0] SRC_NN_FIXED    = 16'd1;
  localparam logic [15:0] SRC_NN_STEP_MIN = 16'd2;
  localparam logic [15:0] SRC_NN_STEP_MAX = 16'd17;
  localparam logic [15:0] SRC_NN_ANA_MAX  = 16'd2;

  typedef enum logic [2:0] {
    SRC_PANEL,
    SRC_ANALOG,
    SRC_MULTISTEP,
    SRC_LINK,
    SRC_OPTION
  } ref_source_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        run_active;
    logic        run_start;
    logic        energy_step;
    logic [15:0] output_current;
    logic [15:0] output_freq;
    logic [15:0] overload_level;
  } drive_status_s;

  typedef struct packed {
    logic        alternate_sel;
    ref_source_e source;
    logic [4:0]  source_index;
    logic [15:0] link_ref;
    logic [15:0] option_ref;
  } reference_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  function automatic logic [15:0] reg_addr(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction

endpackage

// ==== hdl/hour_tick.sv ====
`timescale 1ns/1ns
module hour_tick #(
  parameter longint HOUR_CYCLES = maint_pkg::HOUR_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Counting gate and hourly pulse
  input  wire logic count_en,
  output logic      hour_pulse
);
  import maint_pkg::*;

  typedef struct packed {
    logic [39:0] cycles;
    logic        pulse;
  } tick_state_s;

  localparam logic [39:0] LAST = 40'(HOUR_CYCLES - 64'd1);

  tick_state_s s_q;
  tick_state_s s_d;

  // Partial hour is kept while the gate is closed, so no time is lost
  always_comb begin
    s_d       = s_q;
    s_d.pulse = 1'b0;
    if (count_en) begin
      if (s_q.cycles >= LAST) begin
        s_d.cycles = 40'h00_0000_0000;
        s_d.pulse  = 1'b1;
      end else begin
        s_d.cycles = s_q.cycles + 40'h00_0000_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hour_pulse = s_q.pulse;

endmodule

// ==== hdl/drive_maintenance_monitor_bank.sv ====
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module drive_maintenance_monitor_bank #(
  parameter longint HOUR_CYCLES = maint_pkg::HOUR_CYCLES,
  parameter int     NUM_CELLS   = 9
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [15:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // Drive status from the control core
  input  wire maint_pkg::drive_status_s drive_status,
  input  wire maint_pkg::reference_s    reference,
  // Power cell temperatures, one byte per cell, degrees C
  input  wire logic [NUM_CELLS*8-1:0]   cell_temps
);
  import maint_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [16:0] hours;
    logic [15:0] runs;
    logic [13:0] energy_low;
    logic [16:0] energy_high;
    logic [15:0] peak_current;
    logic [15:0] peak_freq;
    logic [15:0] overload;
    logic [15:0] temperature;
    logic [15:0] source_code;
    logic [15:0] link_ref;
    logic [15:0] option_ref;
    logic        count_on_run;
    logic [31:0] rdata;
    logic        err;
  } bank_state_s;

  bank_state_s s_q;
  bank_state_s s_d;

  apb_req_s req;
  logic     hour_pulse;
  logic     setup_phase;
  logic     access_done;
  logic     wr_done;
  logic     mapped;
  logic [31:0] read_word;
  logic [15:0] source_code_now;
  logic [15:0] hottest_now;
  logic        hour_gate;
  logic        new_peak;
  logic        wr_condition;
  logic        wr_preset;
  logic        wr_run_reset;
  logic [16:0] preset_hours;

  assign req = '{
    psel:    psel,
    penable: penable,
    pwrite:  pwrite,
    paddr:   paddr,
    pwdata:  pwdata
  };

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] wrap_inc17(
    input logic [16:0] v,
    input logic [16:0] max
  );
    return (v >= max) ? 17'h0_0000 : v + 17'h0_0001;
  endfunction

  function automatic logic [15:0] clamp16(
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Out of range preset clears rather than loading an undisplayable value
  function automatic logic [16:0] preset_value(input logic [31:0] d);
    logic [16:0] v;
    v = d[16:0];
    if (d[31:17] != 15'h0000 || v > HOURS_MAX) begin
      v = 17'h0_0000;
    end
    return v;
  endfunction

  // Low digits wrap at 9999 and carry one into the MWh digits
  function automatic logic [30:0] energy_next(
    input logic [13:0] lo,
    input logic [16:0] hi
  );
    logic [13:0] lo_n;
    logic [16:0] hi_n;
    lo_n = lo + 14'h0001;
    hi_n = hi;
    if (lo >= ENERGY_LOW_MAX) begin
      lo_n = 14'h0000;
      hi_n = wrap_inc17(hi, ENERGY_HIGH_MAX);
    end
    return {hi_n, lo_n};
  endfunction

  function automatic logic is_new_peak(
    input drive_status_s d,
    input logic [15:0]   held
  );
    return d.run_active && d.output_current > held;
  endfunction

  function automatic logic [15:0] make_source_code(input reference_s r);
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] nn;
    x  = r.alternate_sel ? SRC_X_ALTERNATE : SRC_X_PRIMARY;
    y  = SRC_Y_PANEL;
    nn = SRC_NN_FIXED;
    unique case (r.source)
      SRC_PANEL: begin
        y = SRC_Y_PANEL;
      end
      SRC_ANALOG: begin
        y  = SRC_Y_ANALOG;
        nn = clamp16({11'h000, r.source_index}, SRC_NN_FIXED, SRC_NN_ANA_MAX);
      end
      SRC_MULTISTEP: begin
        y  = SRC_Y_MULTISTEP;
        nn = clamp16({11'h000, r.source_index}, SRC_NN_STEP_MIN, SRC_NN_STEP_MAX);
      end
      SRC_LINK: begin
        y = SRC_Y_LINK;
      end
      SRC_OPTION: begin
        y = SRC_Y_OPTION;
      end
      default: begin
        y = SRC_Y_PANEL;
      end
    endcase
    return 16'(x * 16'd1000 + y * 16'd100 + nn);
  endfunction

  function automatic logic [15:0] hottest(
    input logic [NUM_CELLS*8-1:0] t
  );
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (t[i*8 +: 8] > m) begin
        m = t[i*8 +: 8];
      end
    end
    return {8'h00, m};
  endfunction

  function automatic logic hit(
    input logic [15:0] a,
    input logic [15:0] idx
  );
    return a == reg_addr(idx);
  endfunction

  // ----------------------------------------------------------------
  // Hour time base
  // ----------------------------------------------------------------
  // Gate follows the condition bit: always powered, or run only
  assign hour_gate = !s_q.count_on_run || drive_status.run_active;

  hour_tick #(
    .HOUR_CYCLES (HOUR_CYCLES)
  ) u_hour_tick (
    .clk        (clk),
    .nrst       (nrst),
    .count_en   (hour_gate),
    .hour_pulse (hour_pulse)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign setup_phase     = req.psel && !req.penable;
  assign access_done     = req.psel && req.penable;
  assign wr_done         = access_done && req.pwrite && !s_q.err;
  assign source_code_now = make_source_code(reference);
  assign hottest_now     = hottest(cell_temps);
  assign new_peak        = is_new_peak(drive_status, s_q.peak_current);

  always_comb begin
    mapped    = 1'b1;
    read_word = RST_ZERO32;
    if (hit(req.paddr, IDX_CUMULATIVE_HOURS)) begin
      read_word = {15'h0000, s_q.hours};
    end else if (hit(req.paddr, IDX_ENERGY_LOW_DIGITS)) begin
      read_word = {18'h0_0000, s_q.energy_low};
    end else if (hit(req.paddr, IDX_ENERGY_HIGH_DIGITS)) begin
      read_word = {15'h0000, s_q.energy_high};
    end else if (hit(req.paddr, IDX_HOTTEST_CELL_TEMP)) begin
      read_word = {16'h0000, s_q.temperature};
    end else if (hit(req.paddr, IDX_RUN_COMMAND_COUNT)) begin
      read_word = {16'h0000, s_q.runs};
    end else if (hit(req.paddr, IDX_PEAK_CURRENT)) begin
      read_word = {16'h0000, s_q.peak_current};
    end else if (hit(req.paddr, IDX_PEAK_CURRENT_FREQ)) begin
      read_word = {16'h0000, s_q.peak_freq};
    end else if (hit(req.paddr, IDX_OVERLOAD_ACCUMULATOR)) begin
      read_word = {16'h0000, s_q.overload};
    end else if (hit(req.paddr, IDX_REFERENCE_SOURCE_CODE)) begin
      read_word = {16'h0000, s_q.source_code};
    end else if (hit(req.paddr, IDX_LINK_FREQ_REFERENCE)) begin
      read_word = {16'h0000, s_q.link_ref};
    end else if (hit(req.paddr, IDX_OPTION_FREQ_REFERENCE)) begin
      read_word = {16'h0000, s_q.option_ref};
    end else if (hit(req.paddr, IDX_HOUR_COUNT_CONDITION)) begin
      read_word = {31'h0000_0000, s_q.count_on_run};
    end else if (hit(req.paddr, IDX_HOUR_COUNTER_PRESET)) begin
      read_word = {15'h0000, s_q.hours};
    end else if (hit(req.paddr, IDX_RUN_COUNT_RESET)) begin
      read_word = RST_ZERO32;
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Setting writes
  // ----------------------------------------------------------------
  // Only setting addresses strobe, so monitor registers never take a write
  always_comb begin
    wr_condition = wr_done && hit(req.paddr, IDX_HOUR_COUNT_CONDITION);
    wr_preset    = wr_done && hit(req.paddr, IDX_HOUR_COUNTER_PRESET);
    wr_run_reset = wr_done && hit(req.paddr, IDX_RUN_COUNT_RESET);
    preset_hours = preset_value(req.pwdata);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Read data and error are latched in setup so they stand through access
    if (setup_phase) begin
      s_d.rdata = mapped ? read_word : RST_ZERO32;
      s_d.err   = !mapped;
    end

    // Operating hours
    if (hour_pulse) begin
      s_d.hours = wrap_inc17(s_q.hours, HOURS_MAX);
    end

    // Run commands
    if (drive_status.run_start) begin
      if (s_q.runs == RUNS_MAX) begin
        s_d.runs = 16'h0000;
      end else begin
        s_d.runs = s_q.runs + 16'h0001;
      end
    end

    // Energy, carried as decimal digits split at 0.1 kWh / MWh
    if (drive_status.energy_step) begin
      {s_d.energy_high, s_d.energy_low} = energy_next(s_q.energy_low, s_q.energy_high);
    end

    // Peak hold only samples while running
    if (new_peak) begin
      s_d.peak_current = drive_status.output_current;
      s_d.peak_freq    = drive_status.output_freq;
    end

    // Live mirrors, registered once to keep bus reads glitch free
    s_d.overload    = drive_status.overload_level;
    s_d.temperature = hottest_now;
    s_d.source_code = source_code_now;
    s_d.link_ref    = reference.link_ref;
    s_d.option_ref  = reference.option_ref;

    // Settings win over a same-cycle hour tick or run start
    if (wr_condition) begin
      s_d.count_on_run = req.pwdata[0];
    end
    if (wr_preset) begin
      s_d.hours = preset_hours;
    end
    if (wr_run_reset) begin
      s_d.runs = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q              <= '0;
      s_q.count_on_run <= RST_COUNT_ON_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states: setup already prepared data and error
  assign pready  = access_done;
  assign prdata  = s_q.rdata;
  assign pslverr = access_done && s_q.err;

endmodule

// ==== verification/maint_bank_chk_sva.sv ====
`timescale 1ns/1ns
module maint_bank_chk
  import maint_pkg::*;
#(
  parameter longint HOUR_CYCLES = maint_pkg::HOUR_CYCLES,
  parameter int     NUM_CELLS   = 9
) (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   nrst,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [15:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  // Drive side
  input wire drive_status_s          drive_status,
  input wire reference_s             reference,
  input wire logic [NUM_CELLS*8-1:0] cell_temps
);
  logic [7:0] hot;

  always_comb begin
    hot = 8'h00;
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (cell_temps[i*8 +: 8] > hot) begin
        hot = cell_temps[i*8 +: 8];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Mirrors need one clean edge before they are readable
  sequence s_setup(logic [15:0] a);
    psel && !penable && paddr == a && $past(nrst);
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  a_ready_access: assert property (s_access |-> pready) else $error("pready low in access");
  a_idle_quiet: assert property (!psel |-> !pready && !pslverr) else $error("idle bus answered");
  a_unmapped_err: assert property (s_setup(16'h0000) ##1 s_access |-> pslverr)
    else $error("unmapped read not refused");
  a_link_mirror: assert property (
    s_setup(16'h1f6c) ##0 $stable(reference.link_ref) |=>
    prdata == {16'h0000, $past(reference.link_ref)}) else $error("link reference wrong");
  a_option_mirror: assert property (
    s_setup(16'h1f70) ##0 $stable(reference.option_ref) |=>
    prdata == {16'h0000, $past(reference.option_ref)}) else $error("option reference wrong");
  a_overload_view: assert property (
    s_setup(16'h1f60) ##0 $stable(drive_status.overload_level) |=>
    prdata == {16'h0000, $past(drive_status.overload_level)}) else $error("overload wrong");
  a_hot_cell: assert property (
    s_setup(16'h01a0) ##0 $stable(cell_temps) |=> prdata == {24'h00_0000, $past(hot)})
    else $error("hottest cell wrong");
  a_source_lead: assert property (
    s_setup(16'h1f68) ##0 $stable(reference) |=>
    prdata / 1000 == ($past(reference.alternate_sel) ? 2 : 1)) else $error("source lead wrong");
  a_hours_limit: assert property (s_setup(16'h0130) |=> prdata <= 32'h0001_869f)
    else $error("hours above limit");
  a_energy_low: assert property (s_setup(16'h0170) |=> prdata <= 32'h0000_270f)
    else $error("energy low digits above limit");
  a_runs_clear: assert property (
    (s_access and (pwrite && paddr == 16'h2008)) ##1 !drive_status.run_start [*2] ##0
    s_setup(16'h01d4) |=> prdata == 32'h0000_0000) else $error("run count not cleared");
endmodule

bind drive_maintenance_monitor_bank maint_bank_chk #(
  .HOUR_CYCLES(HOUR_CYCLES), .NUM_CELLS(NUM_CELLS)) i_chk (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .drive_status(drive_status), .reference(reference), .cell_temps(cell_temps));

// ==== verification/test_drive_maintenance_monitor_bank.sv ====
`timescale 1ns/1ns
module test_drive_maintenance_monitor_bank;
  import maint_pkg::*;
  localparam longint HC = 20;
  localparam int     NC = 3;
  logic            clk, nrst, psel, penable, pwrite, pready, pslverr, re;
  logic [15:0]     paddr;
  logic [31:0]     pwdata, prdata, rv;
  drive_status_s   ds;
  reference_s      rf;
  logic [NC*8-1:0] temps;
  int              num_errors, comparisons;

  drive_maintenance_monitor_bank #(.HOUR_CYCLES(HC), .NUM_CELLS(NC)) i_dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .drive_status(ds), .reference(rf), .cell_temps(temps));

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: read %0h wanted %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: pslverr %b wanted %b", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: no pready", $time);
      close_out();
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk_val(rv, exp);
    chk_bit(re, 1'b0);
  endtask

  // Each read costs three cycles, so the bound is in reads
  task automatic poll(input logic [15:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      xfer(1'b0, a, 32'h0000_0000);
      n++;
    end while (rv !== exp && n < 16);
    chk_val(rv, exp);
  endtask

  task automatic pulse_n(input int n, input logic run);
    repeat (n) begin
      @(posedge clk);
      if (run) begin
        ds.run_start <= 1'b1;
      end else begin
        ds.energy_step <= 1'b1;
      end
      @(posedge clk);
      ds.run_start <= 1'b0;
      ds.energy_step <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_mirror();
    rf.link_ref <= 16'h1234;
    rf.option_ref <= 16'h4321;
    ds.overload_level <= 16'h03e8;
    temps <= {8'h28, 8'h5a, 8'h37};
    repeat (2) @(posedge clk);
    rd(16'h1f6c, 32'h0000_1234);
    rd(16'h1f70, 32'h0000_4321);
    rd(16'h1f60, 32'h0000_03e8);
    rd(16'h01a0, 32'h0000_005a);
    xfer(1'b1, 16'h1f6c, 32'h0000_ffff);
    rd(16'h1f6c, 32'h0000_1234);
    xfer(1'b0, 16'h0000, 32'h0000_0000);
    chk_bit(re, 1'b1);
    chk_val(rv, 32'h0000_0000);
  endtask

  task automatic t_src(input logic alt, input ref_source_e s, input logic [4:0] ix,
                       input logic [31:0] exp);
    rf.alternate_sel <= alt;
    rf.source <= s;
    rf.source_index <= ix;
    repeat (2) @(posedge clk);
    rd(16'h1f68, exp);
  endtask

  task automatic t_runs();
    pulse_n(3, 1'b1);
    rd(16'h01d4, 32'h0000_0003);
    xfer(1'b1, 16'h01d4, 32'h0000_0000);
    rd(16'h01d4, 32'h0000_0003);
    xfer(1'b1, 16'h2008, 32'h0000_0001);
    rd(16'h01d4, 32'h0000_0000);
    pulse_n(1, 1'b1);
    rd(16'h01d4, 32'h0000_0001);
  endtask

  task automatic t_peak(input logic run, input logic [15:0] cur, input logic [15:0] frq,
                        input logic [31:0] ec, input logic [31:0] ef);
    ds.run_active <= run;
    ds.output_current <= cur;
    ds.output_freq <= frq;
    repeat (2) @(posedge clk);
    rd(16'h1f3c, ec);
    rd(16'h1f40, ef);
  endtask

  task automatic t_hours();
    xfer(1'b1, 16'h2000, 32'h0000_0001);
    xfer(1'b1, 16'h2004, 32'h0000_0000);
    rd(16'h0130, 32'h0000_0000);
    repeat (3 * HC) @(posedge clk);
    rd(16'h0130, 32'h0000_0000);
    ds.run_active <= 1'b1;
    poll(16'h0130, 32'h0000_0001);
    ds.run_active <= 1'b0;
    xfer(1'b1, 16'h2000, 32'h0000_0000);
    poll(16'h0130, 32'h0000_0002);
    xfer(1'b1, 16'h2000, 32'h0000_0001);
    xfer(1'b1, 16'h2004, 32'h0001_869f);
    rd(16'h0130, 32'h0001_869f);
    xfer(1'b1, 16'h2004, 32'h0001_86a0);
    rd(16'h0130, 32'h0000_0000);
    xfer(1'b1, 16'h2004, 32'h0001_869f);
    ds.run_active <= 1'b1;
    poll(16'h0130, 32'h0000_0000);
    ds.run_active <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ds = '0;
    rf = '0;
    temps = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_mirror();
    // Expected codes: 1001 2101 1102 2217 1202 1301 2401
    t_src(1'b0, SRC_PANEL, 5'h00, 32'h0000_03e9);
    t_src(1'b1, SRC_ANALOG, 5'h01, 32'h0000_0835);
    t_src(1'b0, SRC_ANALOG, 5'h02, 32'h0000_044e);
    t_src(1'b1, SRC_MULTISTEP, 5'h11, 32'h0000_08a9);
    t_src(1'b0, SRC_MULTISTEP, 5'h02, 32'h0000_04b2);
    t_src(1'b0, SRC_LINK, 5'h00, 32'h0000_0515);
    t_src(1'b1, SRC_OPTION, 5'h00, 32'h0000_0961);
    t_runs();
    t_peak(1'b1, 16'h0064, 16'h01f4, 32'h0000_0064, 32'h0000_01f4);
    t_peak(1'b1, 16'h0032, 16'h0258, 32'h0000_0064, 32'h0000_01f4);
    t_peak(1'b1, 16'h00c8, 16'h02bc, 32'h0000_00c8, 32'h0000_02bc);
    t_peak(1'b0, 16'h012c, 16'h0320, 32'h0000_00c8, 32'h0000_02bc);
    t_hours();
    pulse_n(32'h0000_2711, 1'b0);
    rd(16'h0170, 32'h0000_0001);
    rd(16'h0174, 32'h0000_0001);
    close_out();
  end
endmodule
